/* File: core/pdm_regs.svh */
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH
// Register offsets inside the host peripheral space
`define PDM_RX_PTR_OFS 6'h00
`define PDM_RX_CNT_OFS 6'h04
`define PDM_TX_PTR_OFS 6'h08
`define PDM_TX_CNT_OFS 6'h0C
`define PDM_RXN_PTR_OFS 6'h10
`define PDM_RXN_CNT_OFS 6'h14
`define PDM_TXN_PTR_OFS 6'h18
`define PDM_TXN_CNT_OFS 6'h1C
`define PDM_CTRL_OFS 6'h20
`define PDM_STAT_OFS 6'h24
// Control and status bit positions
`define PDM_RX_EN_BIT 0
`define PDM_RX_DIS_BIT 1
`define PDM_TX_EN_BIT 8
`define PDM_TX_DIS_BIT 9
// Counter field width and reset values
`define PDM_CNT_W 16
`define PDM_PTR_RST 32'h00000000
`define PDM_CNT_RST 16'h0000
// Pointer step per transfer unit
`define PDM_INC_BYTE 32'h00000001
`define PDM_INC_HALF 32'h00000002
`define PDM_INC_WORD 32'h00000004
`endif

/* File: core/pdm_pkg.sv */
package pdm_pkg;
  // Engine states
  typedef enum logic [1:0] {
    PDM_IDLE = 2'b00,
    PDM_RX_MEM = 2'b01,
    PDM_TX_MEM = 2'b10
  } pdm_state_type;
  // Transfer unit sizes
  typedef enum logic [1:0] {
    PDM_BYTE = 2'b00,
    PDM_HALF = 2'b01,
    PDM_WORD = 2'b10
  } pdm_size_type;
endpackage

/* File: core/pdm_channel.sv */
// Contract
// - Ten registers sit at offsets 0x00 to 0x24 of the peripheral space.
// - A 32-bit queued receive address waits for the current buffer.
// - A 16-bit queued receive count pairs with the queued address.
// - Half-duplex: receive and transmit pointers share one register.
// - Half-duplex: receive and transmit counters are one counter.
// - Half-duplex: queued pointers share one register.
// - Half-duplex: queued counters share one register.
// - Receive counter zero stops receive data movement.
// - Transmit counter zero stops transmit data movement.
// - Non-zero counter moves data only while requests are enabled.
// - At zero, a non-zero queued pair loads into current and clears.
// - Each unit advances the pointer by one, two or four bytes.
// - Segment done at counter zero; all done when queued count is zero too.
// - Half-duplex: receive enable turns transmit off; both together forbidden.
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "pdm_regs.svh"
module pdm_channel #(
  parameter bit HALF_DUPLEX = 1'b0
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [5:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Served peripheral
  input wire logic RX_READY,
  input wire logic [31:0] RX_DATA,
  input wire logic TX_READY,
  input wire pdm_pkg::pdm_size_type XFER_SIZE,
  output logic [31:0] TX_DATA,
  output logic TX_LOAD,
  // Memory side
  output logic MEM_REQ,
  output logic MEM_WRITE,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  output pdm_pkg::pdm_size_type MEM_SIZE,
  input wire logic MEM_GNT,
  input wire logic [31:0] MEM_RDATA,
  // Flags to the host status register
  output logic RX_SEGMENT_DONE,
  output logic RX_ALL_DONE,
  output logic TX_SEGMENT_DONE,
  output logic TX_ALL_DONE,
  output logic RX_REQ_ENABLED,
  output logic TX_REQ_ENABLED
);
  import pdm_pkg::*;

  localparam int CW = `PDM_CNT_W;
  localparam bit TS = HALF_DUPLEX ? 1'b0 : 1'b1;

  typedef struct packed {
    pdm_state_type st;
    logic [1:0][31:0] ptr;
    logic [1:0][CW-1:0] cnt;
    logic [1:0][31:0] nptr;
    logic [1:0][CW-1:0] ncnt;
    logic [1:0] en;
    logic [1:0] pend;
    logic [31:0] rx_hold;
    logic [31:0] tx_data;
    logic tx_load;
    logic mem_req;
    logic mem_write;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    pdm_size_type mem_size;
    logic [31:0] prdata;
    logic pslverr;
    logic [3:0] flag;
  } pdm_regs_type;

  pdm_regs_type s;
  pdm_regs_type next_s;
  logic [5:0] ofs;
  logic apb_wr;
  logic cur_sl;
  logic [31:0] cur_inc;

  // Storage slot of a register; half-duplex folds both directions
  function automatic logic slot(input logic [5:0] a);
    slot = HALF_DUPLEX ? 1'b0 : a[3];
  endfunction

  // Pointer step for a unit size
  function automatic logic [31:0] incr(input pdm_size_type sz);
    unique case (sz)
      PDM_BYTE: incr = `PDM_INC_BYTE;
      PDM_HALF: incr = `PDM_INC_HALF;
      PDM_WORD: incr = `PDM_INC_WORD;
      default: incr = `PDM_INC_WORD;
    endcase
  endfunction

  // Address is one of the ten words
  function automatic logic mapped(input logic [5:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `PDM_STAT_OFS);
  endfunction

  // Request decode and the slot of the running transfer
  assign ofs = PADDR;
  assign apb_wr = PSEL && PENABLE && PWRITE && mapped(PADDR);
  assign cur_sl = (s.st == PDM_TX_MEM) ? TS : 1'b0;
  assign cur_inc = incr(s.mem_size);

  // Next state of engine, registers and bus answer
  always_comb begin
    next_s = s;
    next_s.tx_load = 1'b0;
    // Engine
    unique case (s.st)
      PDM_IDLE: begin
        if (s.pend[0] && s.en[0] && s.cnt[0] != `PDM_CNT_RST) begin
          next_s.st = PDM_RX_MEM;
          next_s.mem_req = 1'b1;
          next_s.mem_write = 1'b1;
          next_s.mem_addr = s.ptr[0];
          next_s.mem_wdata = s.rx_hold;
          next_s.mem_size = XFER_SIZE;
        end else if (s.pend[1] && s.en[1] && s.cnt[TS] != `PDM_CNT_RST) begin
          next_s.st = PDM_TX_MEM;
          next_s.mem_req = 1'b1;
          next_s.mem_write = 1'b0;
          next_s.mem_addr = s.ptr[TS];
          next_s.mem_size = XFER_SIZE;
        end
      end
      PDM_RX_MEM, PDM_TX_MEM: begin
        if (MEM_GNT) begin
          next_s.st = PDM_IDLE;
          next_s.mem_req = 1'b0;
          if (s.st == PDM_RX_MEM) begin
            next_s.pend[0] = 1'b0;
          end else begin
            next_s.pend[1] = 1'b0;
            next_s.tx_data = MEM_RDATA;
            next_s.tx_load = 1'b1;
          end
          if (s.cnt[cur_sl] == 16'h0001 && s.ncnt[cur_sl] != `PDM_CNT_RST) begin
            next_s.ptr[cur_sl] = s.nptr[cur_sl];
            next_s.cnt[cur_sl] = s.ncnt[cur_sl];
            next_s.nptr[cur_sl] = `PDM_PTR_RST;
            next_s.ncnt[cur_sl] = `PDM_CNT_RST;
          end else if (s.cnt[cur_sl] != `PDM_CNT_RST) begin
            next_s.ptr[cur_sl] = s.ptr[cur_sl] + cur_inc;
            next_s.cnt[cur_sl] = s.cnt[cur_sl] - 16'h0001;
          end
        end
      end
      default: next_s.st = PDM_IDLE;
    endcase
    // Ready strobes; a new one wins over the clear above
    if (RX_READY) begin
      next_s.pend[0] = 1'b1;
      next_s.rx_hold = RX_DATA;
    end
    if (TX_READY) begin
      next_s.pend[1] = 1'b1;
    end
    // Software writes take priority over the engine
    if (apb_wr) begin
      unique case (ofs)
        `PDM_RX_PTR_OFS, `PDM_TX_PTR_OFS: next_s.ptr[slot(ofs)] = PWDATA;
        `PDM_RX_CNT_OFS, `PDM_TX_CNT_OFS: next_s.cnt[slot(ofs)] = PWDATA[CW-1:0];
        `PDM_RXN_PTR_OFS, `PDM_TXN_PTR_OFS: next_s.nptr[slot(ofs)] = PWDATA;
        `PDM_RXN_CNT_OFS, `PDM_TXN_CNT_OFS: next_s.ncnt[slot(ofs)] = PWDATA[CW-1:0];
        `PDM_CTRL_OFS: begin
          if (HALF_DUPLEX) begin
            if (PWDATA[`PDM_RX_DIS_BIT] || PWDATA[`PDM_TX_DIS_BIT]) begin
              next_s.en = 2'b00;
            end else if (PWDATA[`PDM_RX_EN_BIT]) begin
              next_s.en = 2'b01;
            end else if (PWDATA[`PDM_TX_EN_BIT]) begin
              next_s.en = 2'b10;
            end
          end else begin
            if (PWDATA[`PDM_RX_DIS_BIT]) begin
              next_s.en[0] = 1'b0;
            end else if (PWDATA[`PDM_RX_EN_BIT]) begin
              next_s.en[0] = 1'b1;
            end
            if (PWDATA[`PDM_TX_DIS_BIT]) begin
              next_s.en[1] = 1'b0;
            end else if (PWDATA[`PDM_TX_EN_BIT]) begin
              next_s.en[1] = 1'b1;
            end
          end
        end
        default: next_s.en = next_s.en; // Status word is read-only
      endcase
    end
    // Read data and error are captured in the setup phase
    if (PSEL && !PENABLE) begin
      next_s.pslverr = !mapped(ofs);
      next_s.prdata = 32'h00000000;
      if (mapped(ofs)) begin
        unique case (ofs)
          `PDM_RX_PTR_OFS, `PDM_TX_PTR_OFS: next_s.prdata = s.ptr[slot(ofs)];
          `PDM_RX_CNT_OFS, `PDM_TX_CNT_OFS: next_s.prdata = {16'h0000, s.cnt[slot(ofs)]};
          `PDM_RXN_PTR_OFS, `PDM_TXN_PTR_OFS: next_s.prdata = s.nptr[slot(ofs)];
          `PDM_RXN_CNT_OFS, `PDM_TXN_CNT_OFS: next_s.prdata = {16'h0000, s.ncnt[slot(ofs)]};
          `PDM_STAT_OFS: begin
            next_s.prdata[`PDM_RX_EN_BIT] = s.en[0];
            next_s.prdata[`PDM_TX_EN_BIT] = s.en[1];
          end
          default: next_s.prdata = 32'h00000000; // Control word reads zero
        endcase
      end
    end
    // Flags follow the counters as updated this cycle
    next_s.flag[0] = next_s.cnt[0] == `PDM_CNT_RST;
    next_s.flag[1] = next_s.flag[0] && next_s.ncnt[0] == `PDM_CNT_RST;
    next_s.flag[2] = next_s.cnt[TS] == `PDM_CNT_RST;
    next_s.flag[3] = next_s.flag[2] && next_s.ncnt[TS] == `PDM_CNT_RST;
  end

  // State register; counters reset to zero so all flags start set
  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
      s.flag <= 4'hF;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign PREADY = 1'b1;
  assign PRDATA = s.prdata;
  assign PSLVERR = s.pslverr && PSEL && PENABLE;
  assign TX_DATA = s.tx_data;
  assign TX_LOAD = s.tx_load;
  assign MEM_REQ = s.mem_req;
  assign MEM_WRITE = s.mem_write;
  assign MEM_ADDR = s.mem_addr;
  assign MEM_WDATA = s.mem_wdata;
  assign MEM_SIZE = s.mem_size;
  assign RX_SEGMENT_DONE = s.flag[0];
  assign RX_ALL_DONE = s.flag[1];
  assign TX_SEGMENT_DONE = s.flag[2];
  assign TX_ALL_DONE = s.flag[3];
  assign RX_REQ_ENABLED = s.en[0];
  assign TX_REQ_ENABLED = s.en[1];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Checks
  property p_unmapped;
    (PSEL && !PENABLE && !mapped(PADDR)) ##1 (PSEL && PENABLE) |-> PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_hd_ptr;
    (HALF_DUPLEX && PSEL && !PENABLE && PADDR == `PDM_TX_PTR_OFS)
      |=> PRDATA == $past(s.ptr[0]);
  endproperty
  a_hd_ptr: assert property (p_hd_ptr) else $error("shared pointer read mismatch");

  property p_rx_halt;
    (s.st == PDM_IDLE && s.cnt[0] == `PDM_CNT_RST && !s.pend[1]) |=> s.st == PDM_IDLE;
  endproperty
  a_rx_halt: assert property (p_rx_halt) else $error("receive moved at zero count");

  property p_tx_halt;
    (s.st == PDM_IDLE && s.cnt[TS] == `PDM_CNT_RST) |=> s.st != PDM_TX_MEM;
  endproperty
  a_tx_halt: assert property (p_tx_halt) else $error("transmit moved at zero count");

  property p_rx_start;
    (s.st == PDM_IDLE && s.pend[0] && s.en[0] && s.cnt[0] != `PDM_CNT_RST)
      |=> s.st == PDM_RX_MEM && MEM_REQ && MEM_WRITE && MEM_ADDR == $past(s.ptr[0]);
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("receive did not start");

  property p_reload;
    (s.st != PDM_IDLE && MEM_GNT && !apb_wr && s.cnt[cur_sl] == 16'h0001
      && s.ncnt[cur_sl] != `PDM_CNT_RST)
      |=> s.ncnt[$past(cur_sl)] == `PDM_CNT_RST && s.cnt[$past(cur_sl)] != `PDM_CNT_RST;
  endproperty
  a_reload: assert property (p_reload) else $error("queued pair not loaded");

  property p_advance;
    (s.st != PDM_IDLE && MEM_GNT && !apb_wr && s.cnt[cur_sl] > 16'h0001)
      |=> s.ptr[$past(cur_sl)] == $past(s.ptr[cur_sl]) + $past(cur_inc)
      && s.cnt[$past(cur_sl)] == $past(s.cnt[cur_sl]) - 16'h0001;
  endproperty
  a_advance: assert property (p_advance) else $error("pointer or count step wrong");

  property p_flags;
    RX_ALL_DONE |-> RX_SEGMENT_DONE && s.ncnt[0] == `PDM_CNT_RST && s.cnt[0] == `PDM_CNT_RST;
  endproperty
  a_flags: assert property (p_flags) else $error("done flags inconsistent");

  property p_hd_enable;
    (HALF_DUPLEX && apb_wr && PADDR == `PDM_CTRL_OFS && PWDATA[`PDM_RX_EN_BIT]
      && !PWDATA[`PDM_RX_DIS_BIT] && !PWDATA[`PDM_TX_DIS_BIT])
      |=> RX_REQ_ENABLED && !TX_REQ_ENABLED;
  endproperty
  a_hd_enable: assert property (p_hd_enable) else $error("receive enable kept transmit");

endmodule // pdm_channel

/* File: testbench/pdm_mem_model.sv */
`timescale 1ns/100ps
// Memory bus stand-in: grants each request after a set wait, logs the transfer
module pdm_mem_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Request side
  input wire logic MEM_REQ,
  input wire logic MEM_WRITE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic [3:0] WAIT_CYCLES,
  // Answer side
  output logic MEM_GNT,
  output logic [31:0] MEM_RDATA
);
  logic [3:0] cnt;
  logic [31:0] last_addr;
  logic [31:0] last_wdata;
  logic last_write;
  int units;
  // One grant per request, pulse of one cycle, then the request must drop
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt <= 4'h0;
      MEM_GNT <= 1'b0;
      units <= 0;
    end else if (MEM_REQ && !MEM_GNT && cnt >= WAIT_CYCLES) begin
      MEM_GNT <= 1'b1;
      cnt <= 4'h0;
      units <= units + 1;
      last_addr <= MEM_ADDR;
      last_wdata <= MEM_WDATA;
      last_write <= MEM_WRITE;
    end else begin
      MEM_GNT <= 1'b0;
      cnt <= (MEM_REQ && !MEM_GNT) ? cnt + 4'h1 : 4'h0;
    end
  end
  // Read data valid only while granting; inverted otherwise
  assign MEM_RDATA = MEM_GNT ? {last_addr[15:0], 16'hC35A} : ~{last_addr[15:0], 16'hC35A};
endmodule // pdm_mem_model

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  import pdm_pkg::*;
  logic clk, rst, psel_a, psel_b, penable, pwrite, pready_a, pready_b, perr_a, perr_b, errv;
  logic rx_ready, tx_ready, tx_load, mem_req, mem_write, mem_gnt;
  logic rx_seg, rx_all, tx_seg, tx_all, rx_en, tx_en, hd_rx_en, hd_tx_en;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata_a, prdata_b, rx_data, tx_data, mem_addr, mem_wdata, mem_rdata, rdv;
  logic [3:0] wait_cycles;
  pdm_size_type xfer_size, mem_size;
  int fails, samples_checked, loads;
  // Full-duplex channel against the memory model
  pdm_channel #(.HALF_DUPLEX(1'b0)) pdm_channel_inst (.CLK(clk), .RST(rst), .PSEL(psel_a),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata_a),
    .PREADY(pready_a), .PSLVERR(perr_a), .RX_READY(rx_ready), .RX_DATA(rx_data),
    .TX_READY(tx_ready), .XFER_SIZE(xfer_size), .TX_DATA(tx_data), .TX_LOAD(tx_load),
    .MEM_REQ(mem_req), .MEM_WRITE(mem_write), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_SIZE(mem_size), .MEM_GNT(mem_gnt), .MEM_RDATA(mem_rdata), .RX_SEGMENT_DONE(rx_seg),
    .RX_ALL_DONE(rx_all), .TX_SEGMENT_DONE(tx_seg), .TX_ALL_DONE(tx_all),
    .RX_REQ_ENABLED(rx_en), .TX_REQ_ENABLED(tx_en));
  pdm_mem_model pdm_mem_model_inst (.CLK(clk), .RST(rst), .MEM_REQ(mem_req),
    .MEM_WRITE(mem_write), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .WAIT_CYCLES(wait_cycles), .MEM_GNT(mem_gnt), .MEM_RDATA(mem_rdata));
  // Half-duplex channel, registers only
  pdm_channel #(.HALF_DUPLEX(1'b1)) hd_pdm_channel_inst (.CLK(clk), .RST(rst), .PSEL(psel_b),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata_b),
    .PREADY(pready_b), .PSLVERR(perr_b), .RX_READY(rx_ready), .RX_DATA(rx_data),
    .TX_READY(tx_ready), .XFER_SIZE(xfer_size), .TX_DATA(), .TX_LOAD(), .MEM_REQ(),
    .MEM_WRITE(), .MEM_ADDR(), .MEM_WDATA(), .MEM_SIZE(), .MEM_GNT(1'b0),
    .MEM_RDATA(mem_rdata), .RX_SEGMENT_DONE(), .RX_ALL_DONE(), .TX_SEGMENT_DONE(),
    .TX_ALL_DONE(), .RX_REQ_ENABLED(hd_rx_en), .TX_REQ_ENABLED(hd_tx_en));
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Counts transmit load strobes of the full-duplex channel
  always @(posedge clk) begin
    if (rst) loads <= 0;
    else if (tx_load) loads <= loads + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer: setup, access held until pready is sampled high
  task automatic apb(input bit hd, input bit w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    psel_a <= !hd;
    psel_b <= hd;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (!(hd ? pready_b : pready_a));
    rdv = hd ? prdata_b : prdata_a;
    errv = hd ? perr_b : perr_a;
    psel_a <= 1'b0;
    psel_b <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input bit hd, input logic [5:0] a, input logic [31:0] d);
    apb(hd, 1'b1, a, d);
  endtask
  task automatic rd(input bit hd, input logic [5:0] a, input logic [31:0] e);
    apb(hd, 1'b0, a, 32'h00000000);
    chk(rdv, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input bit tx);
    @(posedge clk);
    if (tx) tx_ready <= 1'b1;
    else rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    tx_ready <= 1'b0;
  endtask
  task automatic wait_units(input int n);
    int k;
    k = 0;
    while (pdm_mem_model_inst.units != n && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk(pdm_mem_model_inst.units, n);
    idle(2);
  endtask
  // Reset values, read-back, refused accesses
  task automatic t_regs;
    for (int i = 0; i < 10; i++) rd(0, 6'(i * 4), 32'h00000000);
    chk({rx_seg, rx_all, tx_seg, tx_all}, 4'hF);
    for (int i = 0; i < 8; i++) begin
      wr(0, 6'(i * 4), 32'hA5A50011 + i);
      rd(0, 6'(i * 4), i[0] ? 32'h00000011 + i : 32'hA5A50011 + i);
    end
    apb(0, 1'b0, 6'h28, 32'h00000000);
    chk(errv, 1'b1);
    apb(0, 1'b0, 6'h02, 32'h00000000);
    chk(errv, 1'b1);
    wr(0, 6'h24, 32'h00000101);
    rd(0, 6'h24, 32'h00000000);
  endtask
  // Receive: blocked while disabled, queued reload, byte step, stop at zero
  task automatic t_rx;
    wr(0, 6'h00, 32'h00001000);
    wr(0, 6'h04, 32'h00000002);
    wr(0, 6'h10, 32'h00002000);
    wr(0, 6'h14, 32'h00000001);
    chk(rx_seg, 1'b0);
    rx_data <= 32'hDEAD0001;
    pulse(0);
    idle(10);
    chk(pdm_mem_model_inst.units, 0);
    wr(0, 6'h20, 32'h00000001);
    wait_units(1);
    chk(pdm_mem_model_inst.last_write, 1'b1);
    chk(pdm_mem_model_inst.last_addr, 32'h00001000);
    chk(pdm_mem_model_inst.last_wdata, 32'hDEAD0001);
    rd(0, 6'h00, 32'h00001004);
    rd(0, 6'h04, 32'h00000001);
    pulse(0);
    wait_units(2);
    rd(0, 6'h00, 32'h00002000);
    rd(0, 6'h14, 32'h00000000);
    xfer_size <= PDM_BYTE;
    pulse(0);
    wait_units(3);
    rd(0, 6'h00, 32'h00002001);
    chk({rx_seg, rx_all}, 2'b11);
    pulse(0);
    idle(10);
    chk(pdm_mem_model_inst.units, 3);
    wr(0, 6'h20, 32'h00000002);
  endtask
  // Transmit with a slow memory, half-word step, stop at zero
  task automatic t_tx;
    xfer_size <= PDM_HALF;
    wait_cycles <= 4'h3;
    wr(0, 6'h08, 32'h00003000);
    wr(0, 6'h0C, 32'h00000001);
    wr(0, 6'h1C, 32'h00000000);
    wr(0, 6'h20, 32'h00000100);
    rd(0, 6'h24, 32'h00000100);
    pulse(1);
    wait_units(4);
    chk(pdm_mem_model_inst.last_write, 1'b0);
    chk(pdm_mem_model_inst.last_addr, 32'h00003000);
    chk(tx_data, 32'h3000C35A);
    chk(loads, 1);
    chk(mem_size, PDM_HALF);
    chk({rx_en, tx_en}, 2'b01);
    rd(0, 6'h08, 32'h00003002);
    chk({tx_seg, tx_all}, 2'b11);
    pulse(1);
    idle(10);
    chk(pdm_mem_model_inst.units, 4);
    chk(loads, 1);
  endtask
  // Half-duplex sharing and receive enable turning transmit off
  task automatic t_hd;
    wr(1, 6'h00, 32'h00004444);
    rd(1, 6'h08, 32'h00004444);
    wr(1, 6'h0C, 32'h00000007);
    rd(1, 6'h04, 32'h00000007);
    wr(1, 6'h18, 32'h00005555);
    rd(1, 6'h10, 32'h00005555);
    wr(1, 6'h14, 32'h00000009);
    rd(1, 6'h1C, 32'h00000009);
    wr(1, 6'h20, 32'h00000100);
    rd(1, 6'h24, 32'h00000100);
    wr(1, 6'h20, 32'h00000001);
    rd(1, 6'h24, 32'h00000001);
    chk({hd_rx_en, hd_tx_en}, 2'b10);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst, psel_a, psel_b, penable, pwrite, paddr, pwdata} = {5'b10000, 6'h00, 32'h0};
    {rx_ready, tx_ready, rx_data, wait_cycles} = {2'b00, 32'h0, 4'h0};
    xfer_size = PDM_WORD;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_rx;
    t_tx;
    t_hd;
    tally_and_finish;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
endmodule // tb
